// >>> inc/tmr_mch_pkg.sv
// Constants and types shared by the multi mode channel register block
package tmr_mch_pkg;
  localparam int unsigned NCH = 4;
  localparam int unsigned VW = 16;
  localparam int unsigned AW = 7;
  localparam logic [6:0] OFF_POL = 7'h50;
  localparam logic [6:0] OFF_VAL0 = 7'h54;
  localparam logic [6:0] OFF_VAL1 = 7'h58;
  localparam logic [6:0] OFF_VAL2 = 7'h5C;
  localparam logic [6:0] OFF_VAL3 = 7'h60;
  localparam logic [6:0] OFF_EXT0 = 7'h64;
  localparam logic [6:0] OFF_EXT1 = 7'h68;
  localparam logic [6:0] OFF_EXT2 = 7'h6C;
  localparam logic [6:0] OFF_EXT3 = 7'h70;
  localparam logic [6:0] OFF_CTL2 = 7'h74;
  localparam logic [31:0] POL_RST = 32'h0000_0000;
  localparam logic [31:0] CTL2_RST = 32'h0FF0_00FF;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [31:0] POL_MASK = 32'h0000_00FF;
  localparam logic [31:0] VAL_MASK = 32'h0000_FFFF;
  localparam logic [31:0] CTL2_MASK = 32'hFFFC_FFFF;
  localparam int unsigned POL_W = 2;
  localparam logic [1:0] POL_HIGH = 2'h0;
  localparam logic [1:0] POL_LOW = 2'h1;
  localparam logic [1:0] POL_BOTH = 2'h3;
  localparam logic [1:0] PAIR_INDEP = 2'h0;
  localparam logic [1:0] PAIR_COMP = 2'h3;
  localparam logic [1:0] MPS_NORMAL = 2'h0;
  localparam logic [1:0] MPS_UP = 2'h1;
  localparam logic [1:0] MPS_DOWN = 2'h2;
  localparam logic [1:0] MPS_BOTH = 2'h3;

  typedef enum logic {BUS_IDLE, BUS_ACK} busState_t;

  typedef struct packed {
    logic [3:0] composite;
    logic [7:0] pairing;
    logic decDisconnect;
    logic decJump;
    logic [1:0] rsvd;
    logic [7:0] pulseSel;
    logic [3:0] breakEn;
    logic [3:0] deadtimeEn;
  } ctl2_t;
endpackage

// >>> rtl/tmr_pin_edge.sv
// Input pin synchroniser with polarity and active edge selection
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_edge (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic pinIn,
  input wire logic enable,
  input wire logic [1:0] polarity,
  output logic capture,
  output logic trigLevel
);
  logic s1_ff;
  logic s2_ff;
  logic prev_ff;
  logic rise;
  logic fall;
  logic hit;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else if (clkEn) begin
      s1_ff <= pinIn;
      s2_ff <= s1_ff;
      prev_ff <= s2_ff;
    end
  end

  assign rise = s2_ff & ~prev_ff;
  assign fall = ~s2_ff & prev_ff;

  always_comb begin
    unique case (polarity)
      tmr_mch_pkg::POL_HIGH: hit = rise;
      tmr_mch_pkg::POL_LOW: hit = fall;
      tmr_mch_pkg::POL_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      capture <= 1'b0;
      trigLevel <= 1'b0;
    end else if (clkEn) begin
      capture <= enable & hit;
      trigLevel <= (polarity == tmr_mch_pkg::POL_LOW) ? ~s2_ff : s2_ff;
    end
  end

  property p_fallCapture;
    @(posedge clk_sys) disable iff (!rst_b)
      (clkEn && enable && polarity == tmr_mch_pkg::POL_LOW && fall) |=> capture;
  endproperty
  a_fallCapture: assert property (p_fallCapture) else $error("falling edge not captured");

  property p_bothEdges;
    @(posedge clk_sys) disable iff (!rst_b)
      (clkEn && enable && polarity == tmr_mch_pkg::POL_BOTH && (rise || fall)) |=> capture;
  endproperty
  a_bothEdges: assert property (p_bothEdges) else $error("edge missed in both-edge mode");
endmodule
`default_nettype wire

// >>> rtl/tmr_cmp_value.sv
// One 16-bit capture/compare value with optional shadow copy and match pulse
`timescale 1ns/1ps
`default_nettype none
module tmr_cmp_value (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic [15:0] wrData,
  input wire logic capture,
  input wire logic [15:0] counter,
  input wire logic shadowOn,
  input wire logic update,
  input wire logic isOutput,
  output logic [15:0] value,
  output logic match
);
  logic [15:0] active_ff;
  logic hitPrev_ff;
  logic [15:0] cmpVal;
  logic hit;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      value <= tmr_mch_pkg::VAL_RST;
    end else if (clkEn) begin
      if (capture) begin
        value <= counter;
      end else if (wrEn) begin
        value <= wrData;
      end
    end
  end

  // Without shadowing the live copy simply tracks the written value
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      active_ff <= tmr_mch_pkg::VAL_RST;
    end else if (clkEn && (update || !shadowOn)) begin
      active_ff <= value;
    end
  end

  assign cmpVal = shadowOn ? active_ff : value;
  assign hit = isOutput && (counter == cmpVal);

  // Pulse only on the first cycle of equality so a stalled counter gives one event
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hitPrev_ff <= 1'b0;
      match <= 1'b0;
    end else if (clkEn) begin
      hitPrev_ff <= hit;
      match <= hit & ~hitPrev_ff;
    end
  end

  property p_shadowHold;
    @(posedge clk_sys) disable iff (!rst_b)
      (shadowOn && !update) |=> $stable(active_ff);
  endproperty
  a_shadowHold: assert property (p_shadowHold) else $error("shadow changed without update");
endmodule
`default_nettype wire

// >>> rtl/tmr_mch_regs.sv
// Multi mode channel polarity, compare value, extra compare and control 2 registers
//
// Function
// - output polarity: 00 high, 01 low
// - input 00 rising noninverted, 01 falling inverted
// - input 11 both edges noninverted, 10 reserved
// - polarity writes ignored at protection 10/11
// - polarity fields at bits 7:0, rest reserved
// - polarity register takes half-word or word
// - input mode: value holds capture, read-only
// - output mode: value compared against counter
// - shadowed compare reloads only at update
// - extra compare per channel, shadowed, composite only
// - bits 31:28 enable composite for channels 3:0
// - control 2 resets to 0x0FF000FF
// - pairing 00 independent, 11 complementary
// - match pulse select: normal, up, down, both
`timescale 1ns/1ps
`default_nettype none
module tmr_mch_regs (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [6:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic updateEvent,
  input wire logic [15:0] counterValue,
  input wire logic countDown,
  input wire logic [1:0] protectionLevel,
  input wire logic [3:0] auxIsOutput,
  input wire logic [3:0] auxShadowEn,
  input wire logic [3:0] extraShadowEn,
  input wire logic [3:0] auxRef,
  input wire logic [3:0] mainRefIn,
  input wire logic [3:0] mainMatch,
  input wire logic [3:0] auxPinIn,
  output logic [3:0] auxPinOut,
  output logic [3:0] auxPinOe,
  output logic [3:0] auxCapture,
  output logic [3:0] auxTrigLevel,
  output logic [3:0] auxMatch,
  output logic [3:0] extraMatch,
  output logic [3:0] mainRefOut,
  output tmr_mch_pkg::ctl2_t ctl2
);
  tmr_mch_pkg::busState_t busSt_ff;
  logic [7:0] polFf;
  logic [31:0] polMerged;
  logic [31:0] rdWord;
  logic wrTake;
  logic [3:0] valWr;
  logic [3:0] extWr;
  logic [15:0] auxVal [4];
  logic [15:0] extVal [4];
  logic [3:0] auxIndep;
  logic [3:0] capEnable;
  logic [3:0] extraHit;
  logic [1:0] pol [4];
  logic [1:0] pair [4];
  logic [1:0] mps [4];

  // Merge write data into a register under the byte enables and a field mask
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // Bus slave: one wait cycle, then an answer cycle with waitrequest low
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busSt_ff <= tmr_mch_pkg::BUS_IDLE;
    end else if (clkEn) begin
      unique case (busSt_ff)
        tmr_mch_pkg::BUS_IDLE: begin
          if (avsRead || avsWrite) begin
            busSt_ff <= tmr_mch_pkg::BUS_ACK;
          end
        end
        tmr_mch_pkg::BUS_ACK: busSt_ff <= tmr_mch_pkg::BUS_IDLE;
      endcase
    end
  end

  // Held off while frozen so that a write is never acknowledged and then lost
  assign avsWaitRequest = (avsRead || avsWrite) && !(clkEn && busSt_ff == tmr_mch_pkg::BUS_ACK);
  assign wrTake = clkEn && avsWrite && (busSt_ff == tmr_mch_pkg::BUS_ACK);

  always_comb begin
    rdWord = 32'h0000_0000;
    unique case (avsAddress)
      tmr_mch_pkg::OFF_POL: rdWord = {24'h00_0000, polFf};
      tmr_mch_pkg::OFF_VAL0: rdWord = {16'h0000, auxVal[0]};
      tmr_mch_pkg::OFF_VAL1: rdWord = {16'h0000, auxVal[1]};
      tmr_mch_pkg::OFF_VAL2: rdWord = {16'h0000, auxVal[2]};
      tmr_mch_pkg::OFF_VAL3: rdWord = {16'h0000, auxVal[3]};
      tmr_mch_pkg::OFF_EXT0: rdWord = {16'h0000, extVal[0]};
      tmr_mch_pkg::OFF_EXT1: rdWord = {16'h0000, extVal[1]};
      tmr_mch_pkg::OFF_EXT2: rdWord = {16'h0000, extVal[2]};
      tmr_mch_pkg::OFF_EXT3: rdWord = {16'h0000, extVal[3]};
      tmr_mch_pkg::OFF_CTL2: rdWord = ctl2;
      default: rdWord = 32'h0000_0000;
    endcase
  end

  // Read data captured on entry to the answer cycle and held through it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avsReadData <= 32'h0000_0000;
    end else if (clkEn && busSt_ff == tmr_mch_pkg::BUS_IDLE && avsRead) begin
      avsReadData <= rdWord;
    end
  end

  // Half-word access works because the merge honours each byte lane
  assign polMerged = mergeBytes({24'h00_0000, polFf}, avsWriteData, avsByteEnable,
                                tmr_mch_pkg::POL_MASK);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      polFf <= tmr_mch_pkg::POL_RST[7:0];
    end else if (wrTake && avsAddress == tmr_mch_pkg::OFF_POL && !protectionLevel[1]) begin
      polFf <= polMerged[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctl2 <= tmr_mch_pkg::CTL2_RST;
    end else if (wrTake && avsAddress == tmr_mch_pkg::OFF_CTL2) begin
      ctl2 <= mergeBytes(ctl2, avsWriteData, avsByteEnable, tmr_mch_pkg::CTL2_MASK);
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_ch
      assign pol[i] = polFf[i*2 +: 2];
      assign pair[i] = ctl2.pairing[i*2 +: 2];
      assign mps[i] = ctl2.pulseSel[i*2 +: 2];
      assign auxIndep[i] = (pair[i] == tmr_mch_pkg::PAIR_INDEP);
      // In complementary pairing only the main channel serves input
      assign capEnable[i] = !auxIsOutput[i] && auxIndep[i];
      // Upper half of the value registers is dropped; software keeps it zero
      assign valWr[i] = wrTake && auxIsOutput[i]
                        && avsAddress == (tmr_mch_pkg::OFF_VAL0 + 7'(i * 4));
      assign extWr[i] = wrTake && avsAddress == (tmr_mch_pkg::OFF_EXT0 + 7'(i * 4));
      assign extraMatch[i] = extraHit[i] & ctl2.composite[i];

      tmr_pin_edge u_pin (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .pinIn(auxPinIn[i]),
        .enable(capEnable[i]),
        .polarity(pol[i]),
        .capture(auxCapture[i]),
        .trigLevel(auxTrigLevel[i])
      );

      tmr_cmp_value u_aux (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .wrEn(valWr[i]),
        .wrData(avsWriteData[15:0]),
        .capture(auxCapture[i]),
        .counter(counterValue),
        .shadowOn(auxShadowEn[i]),
        .update(updateEvent),
        .isOutput(auxIsOutput[i]),
        .value(auxVal[i]),
        .match(auxMatch[i])
      );

      tmr_cmp_value u_ext (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .wrEn(extWr[i]),
        .wrData(avsWriteData[15:0]),
        .capture(1'b0),
        .counter(counterValue),
        .shadowOn(extraShadowEn[i]),
        .update(updateEvent),
        .isOutput(auxIsOutput[i]),
        .value(extVal[i]),
        .match(extraHit[i])
      );

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          auxPinOut[i] <= 1'b0;
          auxPinOe[i] <= 1'b0;
        end else if (clkEn) begin
          auxPinOe[i] <= auxIsOutput[i];
          if (auxIndep[i]) begin
            auxPinOut[i] <= auxRef[i] ^ (pol[i] == tmr_mch_pkg::POL_LOW);
          end else begin
            auxPinOut[i] <= ~mainRefIn[i];
          end
        end
      end

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          mainRefOut[i] <= 1'b0;
        end else if (clkEn) begin
          unique case (mps[i])
            tmr_mch_pkg::MPS_NORMAL: mainRefOut[i] <= mainRefIn[i];
            tmr_mch_pkg::MPS_UP: mainRefOut[i] <= mainMatch[i] & ~countDown;
            tmr_mch_pkg::MPS_DOWN: mainRefOut[i] <= mainMatch[i] & countDown;
            tmr_mch_pkg::MPS_BOTH: mainRefOut[i] <= mainMatch[i];
          endcase
        end
      end
    end
  endgenerate

  sequence s_polWrite;
    clkEn && avsWrite && busSt_ff == tmr_mch_pkg::BUS_ACK && avsAddress == tmr_mch_pkg::OFF_POL;
  endsequence

  property p_polLocked;
    @(posedge clk_sys) disable iff (!rst_b)
      (s_polWrite and protectionLevel[1]) |=> $stable(polFf);
  endproperty
  a_polLocked: assert property (p_polLocked) else $error("polarity changed while locked");

  property p_polLowByte;
    @(posedge clk_sys) disable iff (!rst_b)
      (s_polWrite and (!protectionLevel[1] && avsByteEnable[0]))
        |=> polFf == $past(avsWriteData[7:0]);
  endproperty
  a_polLowByte: assert property (p_polLowByte) else $error("polarity write lost");

  sequence s_request;
    (avsRead || avsWrite) && clkEn && busSt_ff == tmr_mch_pkg::BUS_IDLE;
  endsequence

  property p_answerTime;
    @(posedge clk_sys) disable iff (!rst_b)
      s_request ##1 clkEn |-> !avsWaitRequest;
  endproperty
  a_answerTime: assert property (p_answerTime) else $error("no answer after one wait");

  property p_polReadZero;
    @(posedge clk_sys) disable iff (!rst_b)
      (s_request and (avsRead && avsAddress == tmr_mch_pkg::OFF_POL))
        |=> avsReadData[31:8] == 24'h00_0000;
  endproperty
  a_polReadZero: assert property (p_polReadZero) else $error("reserved bits read nonzero");

  property p_captureLoads;
    @(posedge clk_sys) disable iff (!rst_b)
      (clkEn && auxCapture[0]) |=> auxVal[0] == $past(counterValue);
  endproperty
  a_captureLoads: assert property (p_captureLoads) else $error("capture value wrong");

  property p_inputReadOnly;
    @(posedge clk_sys) disable iff (!rst_b)
      (wrTake && avsAddress == tmr_mch_pkg::OFF_VAL0 && !auxIsOutput[0] && !auxCapture[0])
        |=> $stable(auxVal[0]);
  endproperty
  a_inputReadOnly: assert property (p_inputReadOnly) else $error("input value written");

  property p_activeLow;
    @(posedge clk_sys) disable iff (!rst_b)
      (clkEn && auxIndep[0] && pol[0] == tmr_mch_pkg::POL_LOW)
        |=> auxPinOut[0] == !$past(auxRef[0]);
  endproperty
  a_activeLow: assert property (p_activeLow) else $error("active low output wrong");

  property p_upPulse;
    @(posedge clk_sys) disable iff (!rst_b)
      (clkEn && mps[0] == tmr_mch_pkg::MPS_UP)
        |=> mainRefOut[0] == $past(mainMatch[0] && !countDown);
  endproperty
  a_upPulse: assert property (p_upPulse) else $error("up-count match pulse wrong");

  property p_compositeGate;
    @(posedge clk_sys) disable iff (!rst_b)
      (wrTake && avsAddress == tmr_mch_pkg::OFF_CTL2 && avsByteEnable[3])
        |=> ctl2.composite[1] == $past(avsWriteData[29]);
  endproperty
  a_compositeGate: assert property (p_compositeGate) else $error("composite bit wrong");

  property p_complementOut;
    @(posedge clk_sys) disable iff (!rst_b)
      (clkEn && !auxIndep[0]) |=> auxPinOut[0] == !$past(mainRefIn[0]);
  endproperty
  a_complementOut: assert property (p_complementOut) else $error("pair output wrong");
endmodule
`default_nettype wire

// >>> verif/tmr_mch_regs_test.sv
// Self-checking bench for the multi mode channel register block
`timescale 1ns/1ps
`default_nettype none
module tmr_mch_regs_test;
  logic clk_sys, rst_b, clkEn, avsRead, avsWrite, avsWaitRequest, updateEvent, countDown;
  logic [6:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, rd, exPol;
  logic [3:0] avsByteEnable, auxIsOutput, auxShadowEn, extraShadowEn, auxRef, mainRefIn;
  logic [3:0] mainMatch, auxPinIn, auxPinOut, auxPinOe, auxCapture, auxTrigLevel;
  logic [3:0] auxMatch, extraMatch, mainRefOut, seen;
  logic [15:0] counterValue;
  logic [1:0] protectionLevel;
  tmr_mch_pkg::ctl2_t ctl2;
  int failures, samples_checked;

  tmr_mch_regs u_dut (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .avsAddress(avsAddress),
    .avsRead(avsRead),
    .avsWrite(avsWrite),
    .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest),
    .updateEvent(updateEvent),
    .counterValue(counterValue),
    .countDown(countDown),
    .protectionLevel(protectionLevel),
    .auxIsOutput(auxIsOutput),
    .auxShadowEn(auxShadowEn),
    .extraShadowEn(extraShadowEn),
    .auxRef(auxRef),
    .mainRefIn(mainRefIn),
    .mainMatch(mainMatch),
    .auxPinIn(auxPinIn),
    .auxPinOut(auxPinOut),
    .auxPinOe(auxPinOe),
    .auxCapture(auxCapture),
    .auxTrigLevel(auxTrigLevel),
    .auxMatch(auxMatch),
    .extraMatch(extraMatch),
    .mainRefOut(mainRefOut),
    .ctl2(ctl2)
  );

  task automatic close_out();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Entered just after a rising edge; waitrequest and read data are taken at the
  // rising edge, before the design updates them there
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    avsAddress <= a;
    avsWriteData <= d;
    avsByteEnable <= be;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    if (avsWaitRequest !== 1'b0) begin
      failures++;
      close_out();
    end
    rd = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    // One idle edge so that the next call never reasserts in the same step
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask

  task automatic rchk(input string nm, input logic [6:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    check(nm, rd, exp);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Collects any pulse of one output group over n cycles
  task automatic watch(input int n, input int k);
    seen = 4'h0;
    repeat (n) begin
      @(negedge clk_sys);
      case (k)
        0: seen |= auxMatch;
        1: seen |= extraMatch;
        2: seen |= auxCapture;
        default: seen |= mainRefOut;
      endcase
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    #5000000;
    failures++;
    close_out();
  end

  initial begin
    rst_b = 1'b0;
    clkEn = 1'b1;
    {avsRead, avsWrite, updateEvent, countDown} = 4'h0;
    avsAddress = 7'h00;
    avsWriteData = 32'h0;
    avsByteEnable = 4'h0;
    {auxIsOutput, auxShadowEn, extraShadowEn, auxRef} = 16'h0;
    {mainRefIn, mainMatch, auxPinIn} = 12'h0;
    counterValue = 16'h0;
    protectionLevel = 2'h0;
    failures = 0;
    samples_checked = 0;
    step(4);
    rst_b <= 1'b1;
    step(1);
    check("ctl2 port", ctl2, tmr_mch_pkg::CTL2_RST);
    for (int i = 0; i < 9; i++) begin
      rchk("reset value", 7'h50 + 7'(4 * i), 32'h0);
    end
    rchk("ctl2 reset", 7'h74, tmr_mch_pkg::CTL2_RST);
    wr(7'h78, 32'hFFFF_FFFF, 4'hF);
    rchk("unmapped", 7'h78, 32'h0);
    wr(7'h74, 32'hFFFF_FFFF, 4'hF);
    rchk("ctl2 ones", 7'h74, tmr_mch_pkg::CTL2_MASK);
    check("composite on", {28'h0, ctl2.composite}, 32'hF);
    wr(7'h74, 32'h0, 4'hF);
    check("composite off", {28'h0, ctl2.composite}, 32'h0);
    wr(7'h50, 32'hFFFF_FFFF, 4'hF);
    rchk("pol word", 7'h50, 32'hFF);
    wr(7'h50, 32'h0, 4'h3);
    rchk("pol half", 7'h50, 32'h0);
    exPol = 32'h0;
    for (int p = 0; p < 4; p++) begin
      protectionLevel <= 2'(p);
      wr(7'h50, 32'(8'h44 + p), 4'hF);
      exPol = (p < 2) ? 32'(8'h44 + p) : exPol;
      rchk("pol lock", 7'h50, exPol);
    end
    protectionLevel <= 2'h0;
    auxIsOutput <= 4'hF;
    auxRef <= 4'hF;
    wr(7'h50, 32'h44, 4'hF);
    hold(3);
    check("pin ref high", {28'h0, auxPinOut}, 32'h5);
    check("pin enable", {28'h0, auxPinOe}, 32'hF);
    step(1);
    auxRef <= 4'h0;
    hold(3);
    check("pin ref low", {28'h0, auxPinOut}, 32'hA);
    step(1);
    clkEn <= 1'b0;
    auxRef <= 4'hF;
    hold(3);
    check("frozen", {28'h0, auxPinOut}, 32'hA);
    step(1);
    clkEn <= 1'b1;
    wr(7'h74, 32'h0030_0000, 4'hF);
    hold(3);
    check("complementary", {31'h0, auxPinOut[0]}, 32'h1);
    step(1);
    wr(7'h74, 32'h0, 4'hF);
    wr(7'h54, 32'hFFFF_1234, 4'hF);
    rchk("value upper", 7'h54, 32'h1234);
    counterValue <= 16'h1234;
    hold(1);
    check("match", {31'h0, auxMatch[0]}, 32'h1);
    hold(1);
    check("match once", {31'h0, auxMatch[0]}, 32'h0);
    step(1);
    auxShadowEn <= 4'h2;
    counterValue <= 16'h0042;
    wr(7'h58, 32'h42, 4'hF);
    watch(4, 0);
    check("no early reload", {31'h0, seen[1]}, 32'h0);
    step(1);
    updateEvent <= 1'b1;
    step(1);
    updateEvent <= 1'b0;
    watch(4, 0);
    check("reload at update", {31'h0, seen[1]}, 32'h1);
    step(1);
    counterValue <= 16'h0;
    wr(7'h6C, 32'h77, 4'hF);
    wr(7'h74, 32'h4000_0000, 4'hF);
    counterValue <= 16'h0077;
    watch(4, 1);
    check("extra match", {31'h0, seen[2]}, 32'h1);
    step(1);
    counterValue <= 16'h0;
    wr(7'h74, 32'h0, 4'hF);
    counterValue <= 16'h0077;
    watch(4, 1);
    check("extra gated", {31'h0, seen[2]}, 32'h0);
    step(1);
    auxIsOutput <= 4'h0;
    counterValue <= 16'hABCD;
    wr(7'h50, 32'h34, 4'hF);
    step(4);
    auxPinIn <= 4'h7;
    watch(8, 2);
    check("rise capture", {28'h0, seen}, 32'h5);
    step(1);
    counterValue <= 16'h1111;
    auxPinIn <= 4'h0;
    watch(8, 2);
    check("fall capture", {28'h0, seen}, 32'h6);
    check("trig level", {29'h0, auxTrigLevel[2:0]}, 32'h2);
    step(1);
    rchk("capture ch0", 7'h54, 32'hABCD);
    rchk("capture ch1", 7'h58, 32'h1111);
    rchk("capture ch2", 7'h5C, 32'h1111);
    wr(7'h54, 32'h5555, 4'hF);
    rchk("input read only", 7'h54, 32'hABCD);
    // Each pulse select mode against both count directions
    for (int m = 0; m < 4; m++) begin
      wr(7'h74, 32'(m) << 8, 4'hF);
      for (int dn = 0; dn < 2; dn++) begin
        countDown <= 1'(dn);
        mainMatch <= 4'h1;
        step(1);
        mainMatch <= 4'h0;
        watch(3, 3);
        check("pulse select", {31'h0, seen[0]}, 32'((m == 3) || (m == 1 + dn)));
        step(1);
      end
    end
    wr(7'h74, 32'h0, 4'hF);
    mainRefIn <= 4'h1;
    hold(2);
    check("normal ref", {31'h0, mainRefOut[0]}, 32'h1);
    close_out();
  end
endmodule
`default_nettype wire
